// >>> common/twsad_pkg.sv
// constants, types and states of the two-wire slave address decoder
// assumes one core clock; bus pins arrive raw and are synchronised in the slave
//
// How it works
// - data changes only while clock low; high-phase changes mean START or STOP.
// - after reset the data pin is released and only listened to.
// - START is data falling while clock is high.
// - nothing is taken as a command before a START is seen.
// - STOP is data rising while clock is high; it ends every transaction.
// - a STOP after a read sequence puts the device into standby.
// - transmitter releases after eight bits; receiver pulls low on ninth clock.
// - address byte acknowledged only when identifier bits match, else released.
// - in write direction every further received byte is acknowledged; the slave acknowledges only while its receive FIFO has room.
// - in read mode send eight bits, release, sample acknowledge, continue.
// - no acknowledge after a sent byte stops further sending.
// - the upper address nibble must equal the device type code.
// - address bit 3 must equal the level on the strap pin.
// - bits 2..1 select memory 00, control register 10, potentiometers 11.
// - bit 0 selects direction: 1 read, 0 write.
// - a committed nonvolatile write ending in STOP starts a 5 ms busy cycle.
// - while busy the address is not acknowledged; afterwards normal service.

package twsad_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CORE_CLK_HZ  = 40_000_000;
  localparam int unsigned WR_CYCLE_US  = 5000;
  localparam int unsigned WR_CYCLE_CNT = (CORE_CLK_HZ / 1_000_000) * WR_CYCLE_US;

  // ==========================================================
  // framing, synchroniser and receive FIFO
  localparam logic [3:0]  BYTE_BITS    = 4'h8;
  localparam int unsigned SYNC_PINS    = 3;
  localparam int unsigned RX_FIFO_DEPTH = 32;

  // ==========================================================
  // address byte fields
  localparam int unsigned TYPE_POS     = 4;
  localparam int unsigned STRAP_POS    = 3;
  localparam int unsigned TGT_POS      = 1;
  localparam int unsigned DIR_POS      = 0;
  localparam logic [1:0]  TGT_MEMORY   = 2'h0;
  localparam logic [1:0]  TGT_UNUSED   = 2'h1;
  localparam logic [1:0]  TGT_CONTROL  = 2'h2;
  localparam logic [1:0]  TGT_POT      = 2'h3;
  localparam logic        DIR_READ     = 1'b1;
  // arbitrary neutral value
  localparam logic [3:0]  TYPE_CODE_DFLT = 4'h5;

  // ==========================================================
  // types
  typedef struct packed {
    logic [1:0] target;
    logic       first;
    logic [7:0] data;
  } twsad_rxword_s;

  typedef struct packed {
    logic       selected;
    logic       dirRead;
    logic [1:0] target;
    logic       writeBusy;
    logic       standby;
  } twsad_status_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_WRX,
    ST_RTX,
    ST_RACK,
    ST_RLOAD,
    ST_WAIT
  } twsad_state_e;

endpackage : twsad_pkg

// >>> hw/twsad_fifo.sv
// flip-flop FIFO with valid/ready on both sides
// assumes one clock; writes are refused while full, reads while empty
`timescale 1ns/1ps

module twsad_fifo
#(
  parameter int WIDTH = 11,
  parameter int DEPTH = 32
)
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  // fill side
  input  wire logic             inValid,
  output      logic             inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output      logic             outValid,
  input  wire logic             outReady,
  output      logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_r;
  logic [AW:0]      rdPtr_r;
  logic             full;
  logic             empty;

  assign full     = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
  assign empty    = (wrPtr_r == rdPtr_r);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr_r[AW-1:0]];

  // ==========================================================
  // storage
  always_ff @(posedge core_clk)
    if (inValid && !full)
      mem[wrPtr_r[AW-1:0]] <= inData;

  // ==========================================================
  // pointers
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end
    else
    begin
      if (inValid && !full)
        wrPtr_r <= wrPtr_r + 1'b1;
      if (outReady && !empty)
        rdPtr_r <= rdPtr_r + 1'b1;
    end

endmodule : twsad_fifo

// >>> hw/twsad_slave.sv
// two-wire slave front end: START/STOP, acknowledge, address decode, polling
// assumes open-drain pins resolved outside; command logic supplies read bytes
`timescale 1ns/1ps

module twsad_slave
  import twsad_pkg::*;
#(
  parameter int unsigned WR_CYCLES = WR_CYCLE_CNT,
  parameter logic [3:0]  TYPE_CODE = TYPE_CODE_DFLT
)
(
  // clock and reset
  input  wire logic    core_clk,
  input  wire logic    reset_n,
  // two-wire bus pins
  input  wire logic    sclPin,
  input  wire logic    sdaIn,
  output      logic    sdaOut,
  output      logic    sdaOe,
  // address strap
  input  wire logic    addressStrapPin,
  // received write bytes
  output twsad_rxword_s rxData,
  output      logic    rxValid,
  input  wire logic    rxReady,
  // bytes to send in read mode
  input  wire logic [7:0] txData,
  output      logic    txReady,
  // nonvolatile commit from command logic
  input  wire logic    nvCommit,
  // status
  output twsad_status_s status,
  output      logic    startPulse,
  output      logic    stopPulse
);

  localparam int TW = $clog2(WR_CYCLES + 1);

  // ==========================================================
  // declarations
  logic [SYNC_PINS-1:0] pinRaw;
  logic [SYNC_PINS-1:0] sync1_r;
  logic [SYNC_PINS-1:0] sync2_r;
  logic [SYNC_PINS-1:0] sync3_r;
  logic [SYNC_PINS-1:0] filt_r;
  logic [SYNC_PINS-1:0] lvl;

  twsad_state_e  state_r;
  logic [3:0]    bitCnt_r;
  logic [7:0]    shift_r;
  logic          sdaOe_r;
  logic          readSeq_r;
  logic          writeSeq_r;
  logic          selected_r;
  logic          dirRead_r;
  logic [1:0]    target_r;
  logic          firstByte_r;
  logic          busy_r;
  logic [TW-1:0] busyCnt_r;
  logic          standby_r;
  logic          startPulse_r;
  logic          stopPulse_r;

  logic          sclRise;
  logic          sclFall;
  logic          sdaLvl;
  logic          strapLvl;
  logic          startEv;
  logic          stopEv;
  logic          byteEnd;
  logic          addrMatch;
  logic          addrTake;
  logic          rxInValid;
  logic          rxInReady;
  twsad_rxword_s rxInData;

  // ==========================================================
  // pin synchronisers: three stages, a change counts when stages two and three agree
  assign pinRaw = {addressStrapPin, sdaIn, sclPin};

  generate
    for (genvar i = 0; i < SYNC_PINS; i++)
    begin : g_sync
      always_ff @(posedge core_clk or negedge reset_n)
        if (!reset_n)
        begin
          sync1_r[i] <= 1'b1;
          sync2_r[i] <= 1'b1;
          sync3_r[i] <= 1'b1;
          filt_r[i]  <= 1'b1;
        end
        else
        begin
          sync1_r[i] <= pinRaw[i];
          sync2_r[i] <= sync1_r[i];
          sync3_r[i] <= sync2_r[i];
          filt_r[i]  <= lvl[i];
        end

      assign lvl[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i] : filt_r[i];
    end
  endgenerate

  // ==========================================================
  // bus events
  assign sdaLvl   = lvl[1];
  assign strapLvl = lvl[2];
  assign sclRise  = lvl[0] && !filt_r[0];
  assign sclFall  = !lvl[0] && filt_r[0];
  // data edges while clock stays high are framing, never data
  assign startEv  = lvl[0] && filt_r[0] && filt_r[1] && !lvl[1];
  assign stopEv   = lvl[0] && filt_r[0] && !filt_r[1] && lvl[1];
  assign byteEnd  = sclFall && (bitCnt_r == BYTE_BITS);

  // ==========================================================
  // address decode; the direction bit is not checked, so polls of either kind match
  assign addrMatch = (shift_r[TYPE_POS +: 4] == TYPE_CODE)
                  && (shift_r[STRAP_POS] == strapLvl)
                  && (shift_r[TGT_POS +: 2] != TGT_UNUSED)
                  && !busy_r;
  assign addrTake  = (state_r == ST_ADDR) && byteEnd && addrMatch;

  // write bytes go to the FIFO; a full FIFO withholds the acknowledge
  assign rxInValid = (state_r == ST_WRX) && byteEnd;
  assign rxInData  = '{target: target_r, first: firstByte_r, data: shift_r};

  // a new read byte is taken on the falling edge that ends an acknowledge slot
  assign txReady = sclFall
                && (((state_r == ST_ACK) && dirRead_r) || (state_r == ST_RLOAD));

  // ==========================================================
  // bus sequencer
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      state_r  <= ST_IDLE;
      bitCnt_r <= 4'h0;
      shift_r  <= 8'h00;
      sdaOe_r  <= 1'b0;
    end
    else if (startEv)
    begin
      state_r  <= ST_ADDR;
      bitCnt_r <= 4'h0;
      sdaOe_r  <= 1'b0;
    end
    else if (stopEv)
    begin
      state_r  <= ST_IDLE;
      bitCnt_r <= 4'h0;
      sdaOe_r  <= 1'b0;
    end
    else
      case (state_r)
        ST_ADDR, ST_WRX:
          if (sclRise)
          begin
            shift_r  <= {shift_r[6:0], sdaLvl};
            bitCnt_r <= bitCnt_r + 4'h1;
          end
          else if (byteEnd)
          begin
            bitCnt_r <= 4'h0;
            if ((state_r == ST_ADDR) ? addrMatch : rxInReady)
            begin
              sdaOe_r <= 1'b1;
              state_r <= ST_ACK;
            end
            else
              state_r <= ST_WAIT;
          end
        ST_ACK:
          if (sclFall)
          begin
            if (dirRead_r)
            begin
              shift_r <= txData;
              sdaOe_r <= !txData[7];
              state_r <= ST_RTX;
            end
            else
            begin
              sdaOe_r <= 1'b0;
              state_r <= ST_WRX;
            end
          end
        ST_RTX:
          if (sclRise)
            bitCnt_r <= bitCnt_r + 4'h1;
          else if (byteEnd)
          begin
            bitCnt_r <= 4'h0;
            sdaOe_r  <= 1'b0;
            state_r  <= ST_RACK;
          end
          else if (sclFall)
          begin
            shift_r <= {shift_r[6:0], 1'b0};
            sdaOe_r <= !shift_r[6];
          end
        ST_RACK:
          if (sclRise)
            state_r <= sdaLvl ? ST_WAIT : ST_RLOAD;
        ST_RLOAD:
          if (sclFall)
          begin
            shift_r <= txData;
            sdaOe_r <= !txData[7];
            state_r <= ST_RTX;
          end
        ST_IDLE, ST_WAIT:
          sdaOe_r <= 1'b0;
        default:
        begin
          state_r <= ST_IDLE;
          sdaOe_r <= 1'b0;
        end
      endcase

  // ==========================================================
  // transaction record
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      selected_r  <= 1'b0;
      dirRead_r   <= 1'b0;
      target_r    <= TGT_MEMORY;
      readSeq_r   <= 1'b0;
      writeSeq_r  <= 1'b0;
      firstByte_r <= 1'b0;
    end
    else if (stopEv)
    begin
      selected_r <= 1'b0;
      readSeq_r  <= 1'b0;
      writeSeq_r <= 1'b0;
    end
    else if (startEv)
      selected_r <= 1'b0;
    else if (addrTake)
    begin
      selected_r  <= 1'b1;
      dirRead_r   <= (shift_r[DIR_POS] == DIR_READ);
      target_r    <= shift_r[TGT_POS +: 2];
      readSeq_r   <= readSeq_r || (shift_r[DIR_POS] == DIR_READ);
      writeSeq_r  <= writeSeq_r || (shift_r[DIR_POS] != DIR_READ);
      firstByte_r <= 1'b1;
    end
    else if (rxInValid && rxInReady)
      firstByte_r <= 1'b0;

  // ==========================================================
  // nonvolatile write cycle
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      busy_r    <= 1'b0;
      busyCnt_r <= '0;
    end
    else if (busy_r)
    begin
      busyCnt_r <= busyCnt_r + 1'b1;
      if (busyCnt_r == TW'(WR_CYCLES - 1))
        busy_r <= 1'b0;
    end
    else if (stopEv && writeSeq_r && nvCommit)
    begin
      busy_r    <= 1'b1;
      busyCnt_r <= '0;
    end

  // ==========================================================
  // standby and event pulses
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      standby_r <= 1'b0;
    else if (stopEv && readSeq_r)
      standby_r <= 1'b1;
    else if (startEv)
      standby_r <= 1'b0;

  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      startPulse_r <= 1'b0;
      stopPulse_r  <= 1'b0;
    end
    else
    begin
      startPulse_r <= startEv;
      stopPulse_r  <= stopEv;
    end

  // ==========================================================
  // receive FIFO
  twsad_fifo #(
    .WIDTH ($bits(twsad_rxword_s)),
    .DEPTH (RX_FIFO_DEPTH)
  ) u_rxFifo (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .inValid  (rxInValid),
    .inReady  (rxInReady),
    .inData   (rxInData),
    .outValid (rxValid),
    .outReady (rxReady),
    .outData  (rxData)
  );

  // ==========================================================
  // outputs; the pin is open drain, so only the enable carries data
  assign sdaOut     = 1'b0;
  assign sdaOe      = sdaOe_r;
  assign startPulse = startPulse_r;
  assign stopPulse  = stopPulse_r;
  assign status     = '{selected: selected_r, dirRead: dirRead_r, target: target_r,
                        writeBusy: busy_r, standby: standby_r};

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_addrEnd;
    (state_r == ST_ADDR) && byteEnd;
  endsequence

  sequence s_ackHeld;
    sdaOe_r && (state_r == ST_ACK);
  endsequence

  property p_idleFree;
    (state_r == ST_IDLE || state_r == ST_WAIT) |-> !sdaOe_r;
  endproperty
  a_idleFree: assert property (p_idleFree)
    else $error("data pin driven while idle");

  property p_startAddr;
    startEv |=> (state_r == ST_ADDR) && (bitCnt_r == 4'h0) && !sdaOe_r;
  endproperty
  a_startAddr: assert property (p_startAddr)
    else $error("start did not restart address reception");

  property p_stopIdle;
    stopEv |=> (state_r == ST_IDLE) && !sdaOe_r && !selected_r;
  endproperty
  a_stopIdle: assert property (p_stopIdle)
    else $error("stop did not return to idle");

  property p_standby;
    stopEv && readSeq_r |=> standby_r;
  endproperty
  a_standby: assert property (p_standby)
    else $error("no standby after read sequence");

  property p_addrAck;
    s_addrEnd ##0 addrMatch |=> s_ackHeld;
  endproperty
  a_addrAck: assert property (p_addrAck)
    else $error("matching address not acknowledged");

  property p_addrNack;
    s_addrEnd ##0 (shift_r[TYPE_POS +: 4] != TYPE_CODE || shift_r[STRAP_POS] != strapLvl)
      |=> (state_r == ST_WAIT) && !sdaOe_r;
  endproperty
  a_addrNack: assert property (p_addrNack)
    else $error("foreign address acknowledged");

  property p_tgtUnused;
    s_addrEnd ##0 (shift_r[TGT_POS +: 2] == TGT_UNUSED) |=> !sdaOe_r [*2];
  endproperty
  a_tgtUnused: assert property (p_tgtUnused)
    else $error("unassigned target acknowledged");

  property p_wrAck;
    (state_r == ST_WRX) && byteEnd && rxInReady |=> s_ackHeld;
  endproperty
  a_wrAck: assert property (p_wrAck)
    else $error("write byte not acknowledged");

  property p_ackNine;
    s_ackHeld ##0 sclFall ##0 !dirRead_r |=> !sdaOe_r && (state_r == ST_WRX);
  endproperty
  a_ackNine: assert property (p_ackNine)
    else $error("acknowledge not released after ninth clock");

  property p_rdNack;
    (state_r == ST_RACK) && sclRise && sdaLvl && !stopEv |=> (state_r == ST_WAIT) [*2];
  endproperty
  a_rdNack: assert property (p_rdNack)
    else $error("sending continued without acknowledge");

  property p_rdRelease;
    (state_r == ST_RACK) |-> !sdaOe_r;
  endproperty
  a_rdRelease: assert property (p_rdRelease)
    else $error("data pin held during master acknowledge");

  property p_busyNack;
    s_addrEnd ##0 busy_r |=> !sdaOe_r;
  endproperty
  a_busyNack: assert property (p_busyNack)
    else $error("address acknowledged while busy");

  property p_busyHold;
    $rose(busy_r) |-> busy_r [*8];
  endproperty
  a_busyHold: assert property (p_busyHold)
    else $error("write cycle ended early");

  property p_sdaChange;
    $changed(sdaOe_r) |-> $past(sclFall) || $past(startEv) || $past(stopEv);
  endproperty
  a_sdaChange: assert property (p_sdaChange)
    else $error("data pin changed outside clock low phase");

endmodule : twsad_slave

// >>> verif/twsad_bus_master.sv
// two-wire bus master model: drives the serial clock and pulls data low
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps

module twsad_bus_master
(
  // bus lines
  output logic      scl,
  output logic      sdaPull,
  input  wire logic sda
);
  // ==========================================================
  // bit level
  initial
  begin
    scl     = 1'b1;
    sdaPull = 1'b0;
  end

  // low phase 150 ns lets the slave's late data settle before the rise
  task automatic bitCycle(input logic v, output logic s);
    #25 sdaPull = ~v;
    #125 scl = 1'b1;
    #45 s = sda;
    #5 scl = 1'b0;
  endtask : bitCycle

  // ==========================================================
  // frame level
  task automatic startCond();
    if (scl === 1'b0)
    begin
      #25 sdaPull = 1'b0;
      #200 scl = 1'b1;
    end
    #100 sdaPull = 1'b1;
    #100 scl = 1'b0;
  endtask : startCond

  // data already released by the slave before the clock rises
  task automatic stopCond();
    #25 sdaPull = 1'b1;
    #200 scl = 1'b1;
    #100 sdaPull = 1'b0;
    #100;
  endtask : stopCond

  // eight bits then the acknowledge slot; 1 leaves the line released
  task automatic xfer(input logic [7:0] tx, input logic ackOut,
                      output logic [7:0] rx, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bitCycle(tx[i], s);
      rx[i] = s;
    end
    bitCycle(ackOut, s);
    acked = ~s;
  endtask : xfer
endmodule : twsad_bus_master

// >>> verif/twsad_slave_tb_top.sv
// self-checking bench for the two-wire slave address decoder
// assumes the bus master model drives the link at a 200 ns bit period
`timescale 1ns/1ps

module twsad_slave_tb_top;
  import twsad_pkg::*;
  localparam int unsigned WR = 400;
  // ==========================================================
  // signals
  logic          core_clk = 1'b0;
  logic          reset_n;
  logic          sclPin;
  logic          sdaPull;
  logic          sdaWire;
  logic          sdaOut;
  logic          sdaOe;
  logic          strap;
  twsad_rxword_s rxData;
  logic          rxValid;
  logic          rxReady;
  logic [7:0]    txData;
  logic          txReady;
  logic          nvCommit;
  twsad_status_s status;
  logic          startPulse;
  logic          stopPulse;
  int            nStart = 0;
  int            nStop = 0;
  int            nTx = 0;
  int            err_total = 0;
  int            n_tests = 0;
  int            cycles = 0;
  logic          ack;
  logic [7:0]    rx;
  logic [7:0]    addrTab [6];
  logic          strapTab [6];
  logic          ackTab [6];
  int            t;

  always #12.5 core_clk = ~core_clk;
  assign sdaWire = (sdaOe ? sdaOut : 1'b1) & ~sdaPull;

  twsad_bus_master mst (.scl(sclPin), .sdaPull(sdaPull), .sda(sdaWire));

  twsad_slave #(.WR_CYCLES(WR)) DUT (
    .core_clk(core_clk), .reset_n(reset_n), .sclPin(sclPin), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addressStrapPin(strap), .rxData(rxData),
    .rxValid(rxValid), .rxReady(rxReady), .txData(txData), .txReady(txReady),
    .nvCommit(nvCommit), .status(status), .startPulse(startPulse), .stopPulse(stopPulse));

  // frame events and read-byte requests seen over the whole run
  always @(posedge core_clk)
  begin
    nStart += (startPulse === 1'b1);
    nStop += (stopPulse === 1'b1);
    nTx += (txReady === 1'b1);
  end

  // ==========================================================
  // tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : cyc

  function automatic logic [7:0] addrOf(input logic s, input logic [1:0] tg, input logic d);
    return {TYPE_CODE_DFLT, s, tg, d};
  endfunction : addrOf

  task automatic wrByte(input logic [7:0] b, output logic a);
    logic [7:0] r;
    mst.xfer(b, 1'b1, r, a);
  endtask : wrByte

  task automatic popWord(input logic [10:0] exp);
    int w;
    w = 0;
    while (rxValid !== 1'b1 && w < 100)
    begin
      cyc(1);
      w++;
    end
    check(rxData, exp);
    rxReady = 1'b1;
    cyc(1);
    rxReady = 1'b0;
  endtask : popWord

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_total++;
      complete_run();
    end
  end

  // ==========================================================
  // tests
  initial
  begin
    reset_n = 1'b0;
    rxReady = 1'b0;
    txData = 8'hFF;
    nvCommit = 1'b0;
    strap = 1'b1;
    addrTab = '{{~TYPE_CODE_DFLT, 4'h6}, addrOf(0, TGT_POT, 0), addrOf(1, TGT_UNUSED, 0),
                addrOf(1, TGT_UNUSED, 1), addrOf(1, TGT_POT, 0), addrOf(0, TGT_POT, 0)};
    strapTab = '{1, 1, 1, 1, 0, 0};
    ackTab = '{0, 0, 0, 0, 0, 1};
    repeat (10) @(posedge core_clk);
    #2 reset_n = 1'b1;
    cyc(4);
    check(sdaOe, 0);
    check(sdaOut, 0);
    check(status, 0);
    for (int k = 0; k < 6; k++)
    begin
      strap = strapTab[k];
      cyc(4);
      mst.startCond();
      wrByte(addrTab[k], ack);
      check(ack, ackTab[k]);
      if (k == 0)
      begin
        wrByte(addrOf(1, TGT_MEMORY, 0), ack);
        check(ack, 0);
      end
      mst.stopCond();
    end
    strap = 1'b1;
    cyc(4);
    for (int k = 0; k < 6; k++)
    begin
      mst.startCond();
      wrByte(addrOf(1, (k < 2) ? TGT_MEMORY : (k < 4) ? TGT_CONTROL : TGT_POT, k[0]), ack);
      check(ack, 1);
      check({status.selected, status.dirRead}, {1'b1, k[0]});
      check(status.target, (k < 2) ? TGT_MEMORY : (k < 4) ? TGT_CONTROL : TGT_POT);
      mst.stopCond();
      cyc(4);
      check({status.selected, status.standby}, {1'b0, k[0]});
    end
    // fill the receive buffer until it refuses, then drain it
    mst.startCond();
    wrByte(addrOf(1, TGT_MEMORY, 0), ack);
    for (int i = 0; i < 33; i++)
    begin
      wrByte(i[7:0], ack);
      check(ack, i < 32);
    end
    mst.stopCond();
    for (int i = 0; i < 32; i++)
      popWord({TGT_MEMORY, i == 0, i[7:0]});
    check(rxValid, 0);
    // repeated start inside a write restarts address reception
    mst.startCond();
    wrByte(addrOf(1, TGT_MEMORY, 0), ack);
    wrByte(8'h11, ack);
    mst.startCond();
    wrByte(addrOf(1, TGT_POT, 0), ack);
    check(ack, 1);
    wrByte(8'h22, ack);
    mst.stopCond();
    popWord({TGT_MEMORY, 1'b1, 8'h11});
    popWord({TGT_POT, 1'b1, 8'h22});
    // read: acknowledged byte, refused byte, then silence
    txData = 8'hA5;
    mst.startCond();
    wrByte(addrOf(1, TGT_POT, 1), ack);
    mst.xfer(8'hFF, 1'b0, rx, ack);
    cyc(1);
    txData = 8'h3C;
    check(rx, 8'hA5);
    mst.xfer(8'hFF, 1'b1, rx, ack);
    cyc(1);
    txData = 8'h00;
    check(rx, 8'h3C);
    mst.xfer(8'hFF, 1'b1, rx, ack);
    check(rx, 8'hFF);
    mst.stopCond();
    cyc(4);
    check(status.standby, 1);
    // control register write committed to nonvolatile storage
    mst.startCond();
    wrByte(addrOf(1, TGT_CONTROL, 0), ack);
    wrByte(8'h02, ack);
    nvCommit = 1'b1;
    mst.stopCond();
    cyc(4);
    nvCommit = 1'b0;
    check(status.writeBusy, 1);
    popWord({TGT_CONTROL, 1'b1, 8'h02});
    t = 4;
    mst.startCond();
    wrByte(addrOf(1, TGT_MEMORY, 1), ack);
    check(ack, 0);
    mst.stopCond();
    t = t + 90;
    while (status.writeBusy === 1'b1 && t < 2000)
    begin
      cyc(1);
      t++;
    end
    check((t >= WR - 40) && (t <= WR + 40), 1);
    mst.startCond();
    wrByte(addrOf(1, TGT_MEMORY, 1), ack);
    check(ack, 1);
    mst.xfer(8'hFF, 1'b1, rx, ack);
    mst.stopCond();
    cyc(4);
    check(nStart, 19);
    check(nStop, 18);
    check(nTx, 6);
    complete_run();
  end
endmodule : twsad_slave_tb_top
